// file: rtl/dpsm_top.sv
// Drive power-state manager: tracks active, idle, standby, sleep and gates commands.
// Assumes commands arrive as a one-cycle strobe from same-clock logic; host reset pins are async.
`default_nettype none
module dpsm_top (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // Host resets and power-on
  input  wire logic                       hard_reset_n,
  input  wire logic                       soft_reset,
  input  wire logic                       power_on_done,
  // Command port
  input  wire logic                       cmd_valid,
  input  wire logic [7:0]                 cmd_code,
  input  wire logic                       cmd_media,
  input  wire logic                       exec_done,
  // Power-down control
  input  wire logic                       apd_enable,
  input  wire logic [dpsm_pkg::TMR_W-1:0] apd_period,
  // Command dispatch
  output logic                            exec_start,
  output logic [7:0]                      exec_code,
  output logic                            cmd_done,
  output logic                            cmd_invalid,
  output logic [7:0]                      power_mode,
  output logic                            power_mode_valid,
  // Power state and circuit control
  output logic [3:0]                      power_state,
  output logic                            actuator_driver_on,
  output logic                            spindle_on,
  output logic                            circuits_full
);
  import dpsm_pkg::*;

  typedef enum logic [2:0] {
    DPSM_X_IDLE  = 3'h1,
    DPSM_X_SPIN  = 3'h2,
    DPSM_X_EXEC  = 3'h4
  } dpsm_xs_t;

  function automatic logic is_power_cmd(input logic [7:0] c);
    is_power_cmd = (c == CMD_IDLE) || (c == CMD_IDLE_IMM) || (c == CMD_STANDBY) ||
                   (c == CMD_STANDBY_IMM) || (c == CMD_SLEEP) || (c == CMD_CHECK_POWER);
  endfunction : is_power_cmd

  function automatic logic is_standby_cmd(input logic [7:0] c);
    is_standby_cmd = (c == CMD_STANDBY) || (c == CMD_STANDBY_IMM);
  endfunction : is_standby_cmd

  function automatic logic is_idle_cmd(input logic [7:0] c);
    is_idle_cmd = (c == CMD_IDLE) || (c == CMD_IDLE_IMM);
  endfunction : is_idle_cmd

  function automatic logic is_instant_cmd(input logic [7:0] c);
    is_instant_cmd = is_power_cmd(c) || (c == CMD_INIT_PARAMS);
  endfunction : is_instant_cmd

  function automatic logic motor_wanted(input dpsm_state_t s, input dpsm_xs_t x);
    motor_wanted = (s == DPSM_ACTIVE) || (s == DPSM_IDLE) || (x == DPSM_X_SPIN);
  endfunction : motor_wanted

  // Synchronised host resets and power-on
  logic hard_rst_sync;
  logic soft_rst_sync;
  logic pon_sync;
  dpsm_sync u_sync_hard (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d_in    (~hard_reset_n),
    .q_out   (hard_rst_sync)
  );
  dpsm_sync u_sync_soft (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d_in    (soft_reset),
    .q_out   (soft_rst_sync)
  );
  dpsm_sync u_sync_pon (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d_in    (power_on_done),
    .q_out   (pon_sync)
  );

  // Edge detection on synchronised levels
  logic host_rst_lvl;
  logic host_rst_d_ff;
  logic pon_d_ff;
  logic host_rst_rise;
  logic pon_rise;
  assign host_rst_lvl = hard_rst_sync | soft_rst_sync;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      host_rst_d_ff <= 1'b0;
    end else begin
      host_rst_d_ff <= host_rst_lvl;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pon_d_ff <= 1'b0;
    end else begin
      pon_d_ff <= pon_sync;
    end
  end
  assign host_rst_rise = host_rst_lvl & ~host_rst_d_ff;
  assign pon_rise      = pon_sync & ~pon_d_ff;

  // Power-down timer
  logic apd_expired;
  logic apd_restart;
  dpsm_timer u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .enable  (apd_enable),
    .restart (apd_restart),
    .period  (apd_period),
    .expired (apd_expired)
  );

  // State registers
  dpsm_state_t state_ff;
  dpsm_state_t nxt_state;
  dpsm_xs_t    xs_ff;
  dpsm_xs_t    nxt_xs;
  logic [7:0]  pend_code_ff;
  logic [15:0] spin_cnt_ff;
  logic        cmd_accept;
  logic        needs_spin;
  logic        spin_done;

  // Sleep refuses all commands; busy execution also refuses new ones
  assign cmd_accept = cmd_valid && (state_ff != DPSM_SLEEP) && (xs_ff == DPSM_X_IDLE);
  assign needs_spin = cmd_media && (state_ff == DPSM_STANDBY) && !is_power_cmd(cmd_code);
  assign spin_done  = (spin_cnt_ff == SPINUP_CYC);

  // Timer restarts on any command, host reset or running command
  assign apd_restart = cmd_valid | host_rst_rise | (xs_ff != DPSM_X_IDLE);

  // Power-state transitions
  always_comb begin
    nxt_state = state_ff;
    if (host_rst_rise) begin
      if (state_ff == DPSM_SLEEP) begin
        nxt_state = DPSM_STANDBY;
      end else if (state_ff == DPSM_STANDBY) begin
        nxt_state = DPSM_STANDBY;
      end else begin
        nxt_state = DPSM_ACTIVE;
      end
    end else if (pon_rise && state_ff != DPSM_SLEEP) begin
      nxt_state = DPSM_ACTIVE;
    end else if (cmd_accept) begin
      if (cmd_code == CMD_SLEEP) begin
        nxt_state = DPSM_SLEEP;
      end else if (is_standby_cmd(cmd_code)) begin
        nxt_state = DPSM_STANDBY;
      end else if (is_idle_cmd(cmd_code)) begin
        nxt_state = DPSM_IDLE;
      end else if (cmd_code == CMD_CHECK_POWER || cmd_code == CMD_INIT_PARAMS) begin
        nxt_state = state_ff;
      end else begin
        nxt_state = DPSM_ACTIVE;
      end
    end else if (state_ff == DPSM_ACTIVE && xs_ff == DPSM_X_IDLE) begin
      nxt_state = DPSM_IDLE;
    end else if (apd_expired && (state_ff == DPSM_IDLE || state_ff == DPSM_ACTIVE) && xs_ff == DPSM_X_IDLE) begin
      nxt_state = DPSM_STANDBY;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= DPSM_ACTIVE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Command execution sequencing
  always_comb begin
    nxt_xs = xs_ff;
    unique case (xs_ff)
      DPSM_X_IDLE: begin
        if (cmd_accept && !is_instant_cmd(cmd_code)) begin
          nxt_xs = needs_spin ? DPSM_X_SPIN : DPSM_X_EXEC;
        end
      end
      DPSM_X_SPIN: begin
        if (spin_done) begin
          nxt_xs = DPSM_X_EXEC;
        end
      end
      DPSM_X_EXEC: begin
        if (exec_done) begin
          nxt_xs = DPSM_X_IDLE;
        end
      end
      default: nxt_xs = DPSM_X_IDLE;
    endcase
    if (host_rst_rise) begin
      nxt_xs = DPSM_X_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      xs_ff <= DPSM_X_IDLE;
    end else begin
      xs_ff <= nxt_xs;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || xs_ff != DPSM_X_SPIN) begin
      spin_cnt_ff <= 16'h0000;
    end else begin
      spin_cnt_ff <= spin_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend_code_ff <= 8'h00;
    end else if (cmd_accept) begin
      pend_code_ff <= cmd_code;
    end
  end

  // Dispatch and completion outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      exec_start <= 1'b0;
    end else begin
      exec_start <= (xs_ff != DPSM_X_EXEC) && (nxt_xs == DPSM_X_EXEC) && !host_rst_rise;
    end
  end

  // A deferred command presents its code from the pending register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      exec_code <= 8'h00;
    end else begin
      exec_code <= (nxt_xs == DPSM_X_EXEC && xs_ff == DPSM_X_SPIN) ? pend_code_ff : cmd_code;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= (cmd_accept && is_instant_cmd(cmd_code)) || (xs_ff == DPSM_X_EXEC && exec_done);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_invalid <= 1'b0;
    end else begin
      cmd_invalid <= cmd_valid && (state_ff == DPSM_SLEEP);
    end
  end

  // Check power mode answer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      power_mode_valid <= 1'b0;
    end else begin
      power_mode_valid <= cmd_accept && (cmd_code == CMD_CHECK_POWER);
    end
  end

  // Encoding follows the state held when the query is taken
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      power_mode <= PMODE_ACTIVE;
    end else begin
      unique case (state_ff)
        DPSM_STANDBY: power_mode <= PMODE_STANDBY;
        DPSM_IDLE:    power_mode <= PMODE_IDLE;
        default:      power_mode <= PMODE_ACTIVE;
      endcase
    end
  end

  // Circuit power controls, registered from the next state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      power_state <= DPSM_ACTIVE;
    end else begin
      power_state <= nxt_state;
    end
  end

  // Actuator driver and spindle run only when the medium may be reached
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      actuator_driver_on <= 1'b1;
    end else begin
      actuator_driver_on <= motor_wanted(nxt_state, nxt_xs);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      spindle_on <= 1'b1;
    end else begin
      spindle_on <= motor_wanted(nxt_state, nxt_xs);
    end
  end

  // Only active keeps every circuit powered
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      circuits_full <= 1'b1;
    end else begin
      circuits_full <= (nxt_state == DPSM_ACTIVE);
    end
  end
endmodule : dpsm_top
`default_nettype wire

// file: rtl/dpsm_pkg.sv
// Package: power states, command codes and timing for the drive power-state manager.
// Assumes a 20 MHz system clock.
`default_nettype none
package dpsm_pkg;
  typedef enum logic [3:0] {
    DPSM_ACTIVE  = 4'h1,
    DPSM_IDLE    = 4'h2,
    DPSM_STANDBY = 4'h4,
    DPSM_SLEEP   = 4'h8
  } dpsm_state_t;
  localparam logic [7:0] CMD_STANDBY_IMM  = 8'hE0;
  localparam logic [7:0] CMD_IDLE_IMM     = 8'hE1;
  localparam logic [7:0] CMD_STANDBY      = 8'hE2;
  localparam logic [7:0] CMD_IDLE         = 8'hE3;
  localparam logic [7:0] CMD_CHECK_POWER  = 8'hE5;
  localparam logic [7:0] CMD_SLEEP        = 8'hE6;
  localparam logic [7:0] CMD_INIT_PARAMS  = 8'h91;
  localparam logic [7:0] PMODE_STANDBY    = 8'h00;
  localparam logic [7:0] PMODE_IDLE       = 8'h80;
  localparam logic [7:0] PMODE_ACTIVE     = 8'hFF;
  localparam int         CLK_HZ           = 20_000_000;
  localparam int         TMR_W            = 32;
  localparam int         APD_DEFAULT_MS   = 5000;
  localparam logic [TMR_W-1:0] APD_DEFAULT_CYC = TMR_W'(64'(APD_DEFAULT_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam int         SPINUP_US        = 10;
  localparam logic [15:0] SPINUP_CYC = 16'((SPINUP_US * (CLK_HZ / 1_000_000)));
endpackage : dpsm_pkg
`default_nettype wire

// file: rtl/dpsm_sync.sv
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes clk_sys and a synchronous active-high reset.
`default_nettype none
module dpsm_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Level
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_ff;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_ff <= 1'b0;
      q_out   <= 1'b0;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end
endmodule : dpsm_sync
`default_nettype wire

// file: rtl/dpsm_timer.sv
// Automatic power-down timer: restarts on command, holds expired high from expiry until restarted.
// Assumes clk_sys and a synchronous active-high reset.
`default_nettype none
module dpsm_timer (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // Control
  input  wire logic                      enable,
  input  wire logic                      restart,
  input  wire logic [dpsm_pkg::TMR_W-1:0] period,
  // Expiry
  output logic                           expired
);
  import dpsm_pkg::*;
  logic [TMR_W-1:0] count_ff;
  always_ff @(posedge clk_sys) begin
    if (reset || !enable || restart) begin
      count_ff <= '0;
      expired  <= 1'b0;
    end else if (count_ff + TMR_W'(1) >= period) begin
      expired  <= 1'b1;
    end else begin
      count_ff <= count_ff + TMR_W'(1);
      expired  <= 1'b0;
    end
  end
endmodule : dpsm_timer
`default_nettype wire

// file: bench/dpsm_assertions.sv
// Checker: port properties of the power-state manager.
// Assumes it is bound onto dpsm_top, one clock, synchronous reset.
`default_nettype none
module dpsm_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Command port
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic       cmd_media,
  input wire logic       exec_done,
  // Dispatch and state
  input wire logic       exec_start,
  input wire logic [7:0] exec_code,
  input wire logic       cmd_done,
  input wire logic       cmd_invalid,
  input wire logic [7:0] power_mode,
  input wire logic       power_mode_valid,
  input wire logic [3:0] power_state,
  input wire logic       circuits_full
);
  import dpsm_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_cmd(logic [7:0] c);
    cmd_valid && cmd_code == c;
  endsequence
  sequence s_pwr_idle;
    cmd_valid && power_state == DPSM_IDLE && cmd_code inside {8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE5, 8'hE6};
  endsequence
  sequence s_stby_idle;
    (s_cmd(CMD_STANDBY_IMM) or s_cmd(CMD_STANDBY)) ##0 power_state == DPSM_IDLE;
  endsequence
  a_one_hot: assert property ($onehot(power_state)) else $error("power state not one-hot");
  a_full_active: assert property (circuits_full == (power_state == DPSM_ACTIVE))
    else $error("full power outside active");
  a_work_active: assert property (cmd_valid && !cmd_media && power_state == DPSM_IDLE &&
    !(cmd_code inside {8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE5, 8'hE6, 8'h91})
    |=> exec_start && exec_code == $past(cmd_code) && power_state == DPSM_ACTIVE) else $error("no dispatch");
  a_done_idle: assert property (exec_done ##1 !cmd_valid |-> cmd_done ##1 power_state == DPSM_IDLE)
    else $error("completion not idle");
  a_pwr_no_active: assert property (s_pwr_idle |=> (!exec_start && power_state != DPSM_ACTIVE)[*2])
    else $error("power command went active");
  a_enter_stby: assert property (s_stby_idle |-> ##[1:2] power_state == DPSM_STANDBY)
    else $error("standby not entered");
  a_sleep_entry: assert property ($rose(power_state == DPSM_SLEEP) |->
    $past(cmd_valid && cmd_code == CMD_SLEEP) || $past(cmd_valid && cmd_code == CMD_SLEEP, 2))
    else $error("sleep without command");
  a_sleep_mute: assert property (cmd_valid && power_state == DPSM_SLEEP |=> cmd_invalid && !exec_start && !cmd_done)
    else $error("command acted in sleep");
  a_sleep_exit: assert property (power_state == DPSM_SLEEP |=> power_state inside {DPSM_SLEEP, DPSM_STANDBY})
    else $error("sleep left to wrong state");
  a_check_mode: assert property (s_cmd(CMD_CHECK_POWER) ##0 power_state inside {DPSM_IDLE, DPSM_STANDBY}
    |=> power_mode_valid && $stable(power_state) &&
    power_mode == ($past(power_state) == DPSM_STANDBY ? PMODE_STANDBY : PMODE_IDLE)) else $error("bad mode");
endmodule : dpsm_chk
bind dpsm_top dpsm_chk dpsm_chk_i (
  .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_media(cmd_media),
  .exec_done(exec_done), .exec_start(exec_start), .exec_code(exec_code), .cmd_done(cmd_done),
  .cmd_invalid(cmd_invalid), .power_mode(power_mode), .power_mode_valid(power_mode_valid),
  .power_state(power_state), .circuits_full(circuits_full)
);
`default_nettype wire

// file: bench/dpsm_host_model.sv
// Host model: issues one-cycle commands and plays the command executor.
// Assumes the same clock as the design; exec_dly sets executor speed.
`default_nettype none
module dpsm_host_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Command side
  output logic            cmd_valid,
  output logic [7:0]      cmd_code,
  output logic            cmd_media,
  // Executor side
  input  wire logic       exec_start,
  output logic            exec_done
);
  int         exec_dly;
  logic [7:0] wait_ff;
  initial begin
    exec_dly = 2;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_media = 1'b0;
  end
  // Released lines show the inverse of the last value
  task send(input logic [7:0] c, input logic m);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_media <= m;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_media <= ~m;
  endtask : send
  always @(posedge clk_sys) begin
    exec_done <= !reset && !exec_start && (wait_ff == 8'h01);
    if (reset) begin
      wait_ff <= 8'h00;
    end else if (exec_start) begin
      wait_ff <= 8'(exec_dly);
    end else if (wait_ff != 8'h00) begin
      wait_ff <= wait_ff - 8'h01;
    end
  end
endmodule : dpsm_host_model
`default_nettype wire

// file: bench/dpsm_tb.sv
// Testbench: walks the power states through host commands and resets.
// Assumes the checker binds itself onto dpsm_top.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dpsm_pkg::*;
  logic             clk_sys;
  logic             reset;
  logic             hard_reset_n;
  logic             soft_reset;
  logic             power_on_done;
  logic             cmd_valid;
  logic [7:0]       cmd_code;
  logic             cmd_media;
  logic             exec_done;
  logic             apd_enable;
  logic [TMR_W-1:0] apd_period;
  logic             exec_start;
  logic [7:0]       exec_code;
  logic             cmd_done;
  logic             cmd_invalid;
  logic [7:0]       power_mode;
  logic             power_mode_valid;
  logic [3:0]       power_state;
  logic             actuator_driver_on;
  logic             spindle_on;
  logic             circuits_full;
  int               err_total;
  int               check_count;
  dpsm_top dpsm_top_i (.clk_sys(clk_sys), .reset(reset), .hard_reset_n(hard_reset_n), .soft_reset(soft_reset),
    .power_on_done(power_on_done), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_media(cmd_media),
    .exec_done(exec_done), .apd_enable(apd_enable), .apd_period(apd_period), .exec_start(exec_start),
    .exec_code(exec_code), .cmd_done(cmd_done), .cmd_invalid(cmd_invalid), .power_mode(power_mode),
    .power_mode_valid(power_mode_valid), .power_state(power_state), .actuator_driver_on(actuator_driver_on),
    .spindle_on(spindle_on), .circuits_full(circuits_full));
  dpsm_host_model dpsm_host_model_i (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_media(cmd_media), .exec_start(exec_start), .exec_done(exec_done));
  task chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task do_cmd(input logic [7:0] c, input logic m);
    dpsm_host_model_i.send(c, m);
    #1;
  endtask : do_cmd
  task wait_st(input dpsm_state_t s, input int lim);
    int n;
    n = 0;
    while (power_state !== s && n < lim) begin
      tick(1);
      n++;
    end
    chk(power_state === s, "state not reached");
  endtask : wait_st
  task wait_done(input int lim);
    int n;
    n = 0;
    while (cmd_done !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    chk(cmd_done === 1'b1, "no completion");
  endtask : wait_done
  task t_work;
    dpsm_host_model_i.exec_dly = 30;
    do_cmd(8'h20, 1'b0);
    chk(exec_start === 1'b1 && exec_code === 8'h20 && power_state === DPSM_ACTIVE, "no dispatch");
    chk(circuits_full === 1'b1, "not full power");
    wait_done(40);
    tick(1);
    chk(power_state === DPSM_IDLE && circuits_full === 1'b0, "not idle");
    dpsm_host_model_i.exec_dly = 2;
  endtask : t_work
  task t_pwr;
    logic [7:0] pc [3] = '{CMD_IDLE_IMM, CMD_IDLE, CMD_CHECK_POWER};
    foreach (pc[i]) begin
      do_cmd(pc[i], 1'b0);
      chk(cmd_done === 1'b1 && exec_start === 1'b0 && power_state === DPSM_IDLE, "power cmd");
    end
    chk(power_mode_valid === 1'b1 && power_mode === PMODE_IDLE, "mode idle");
  endtask : t_pwr
  task t_standby;
    logic [7:0] sc [4] = '{CMD_STANDBY_IMM, CMD_STANDBY, CMD_INIT_PARAMS, CMD_CHECK_POWER};
    int n;
    for (int j = 0; j < 2; j++) begin
      do_cmd(sc[j], 1'b0);
      wait_st(DPSM_STANDBY, 2);
      chk(actuator_driver_on === 1'b0 && spindle_on === 1'b0, "motor on");
      if (j == 0) begin
        do_cmd(CMD_IDLE_IMM, 1'b0);
        wait_st(DPSM_IDLE, 2);
      end
    end
    foreach (sc[i]) begin
      do_cmd(sc[i], 1'b0);
      chk(cmd_done === 1'b1 && power_state === DPSM_STANDBY, "left standby");
    end
    chk(power_mode_valid === 1'b1 && power_mode === PMODE_STANDBY, "mode standby");
    @(posedge clk_sys);
    soft_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    soft_reset <= 1'b0;
    tick(8);
    chk(power_state === DPSM_STANDBY, "reset left standby");
    do_cmd(8'h30, 1'b1);
    n = 0;
    while (exec_start !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk(n >= int'(SPINUP_CYC) && n <= int'(SPINUP_CYC) + 1 && spindle_on === 1'b1, "spin-up delay");
    chk(exec_code === 8'h30, "deferred code");
    wait_done(10);
    tick(1);
    chk(power_state === DPSM_IDLE, "not idle");
  endtask : t_standby
  task t_sleep;
    logic [7:0] zc [2] = '{8'h20, CMD_IDLE};
    for (int j = 0; j < 2; j++) begin
      do_cmd(CMD_SLEEP, 1'b0);
      wait_st(DPSM_SLEEP, 2);
      foreach (zc[i]) begin
        do_cmd(zc[i], 1'b0);
        chk(cmd_invalid === 1'b1 && exec_start === 1'b0 && cmd_done === 1'b0, "sleep not mute");
      end
      chk(power_state === DPSM_SLEEP, "left sleep");
      @(posedge clk_sys);
      soft_reset <= (j == 0);
      hard_reset_n <= (j == 0);
      repeat (2) @(posedge clk_sys);
      soft_reset <= 1'b0;
      hard_reset_n <= 1'b1;
      wait_st(DPSM_STANDBY, 8);
      do_cmd(CMD_IDLE_IMM, 1'b0);
      wait_st(DPSM_IDLE, 2);
    end
  endtask : t_sleep
  task t_apd;
    @(posedge clk_sys);
    apd_enable <= 1'b1;
    do_cmd(8'h20, 1'b0);
    wait_done(10);
    tick(1);
    chk(power_state === DPSM_IDLE, "idle blocked");
    tick(10);
    do_cmd(CMD_IDLE, 1'b0);
    tick(15);
    chk(power_state === DPSM_IDLE, "timer not restarted");
    wait_st(DPSM_STANDBY, 12);
  endtask : t_apd
  task wrap_up;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end
  initial begin
    err_total = 0;
    check_count = 0;
    reset = 1'b1;
    hard_reset_n = 1'b1;
    soft_reset = 1'b0;
    power_on_done = 1'b0;
    apd_enable = 1'b0;
    apd_period = TMR_W'(20);
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    wait_st(DPSM_IDLE, 4);
    @(posedge clk_sys);
    power_on_done <= 1'b1;
    wait_st(DPSM_ACTIVE, 8);
    wait_st(DPSM_IDLE, 4);
    t_work();
    t_pwr();
    t_standby();
    t_sleep();
    t_apd();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
